// ---- rtl/epi_map.svh ----
// Register indices, field positions and reset values of the pin interrupt unit.
`ifndef EPI_MAP_SVH
`define EPI_MAP_SVH

`define EPI_IDX_W 7
`define EPI_ADR_MSB 8
`define EPI_ADR_LSB 2
`define EPI_BYTE_W 8
`define EPI_SENSE_W 2
`define EPI_ARM_W 3

`define EPI_IDX_DED_EN 7'h1d
`define EPI_IDX_GRP_EN 7'h68
`define EPI_IDX_SENSE 7'h20
`define EPI_IDX_DED_FLAG 7'h1c
`define EPI_IDX_GRP_FLAG 7'h1b
`define EPI_IDX_MASK0 7'h6b
`define EPI_IDX_MASK1 7'h6c
`define EPI_IDX_MASK2 7'h6d
`define EPI_IDX_MASK3 7'h73

`define EPI_RESET_BYTE 8'h00
`define EPI_PAD_ZERO 24'h00_0000

`endif

// ---- rtl/epi_pkg.sv ----
// Types shared by the pin interrupt unit.
package epi_pkg;

    typedef enum logic [1:0] {
        EPI_SENSE_LOW = 2'h0,
        EPI_SENSE_ANY = 2'h1,
        EPI_SENSE_FALL = 2'h2,
        EPI_SENSE_RISE = 2'h3
    } epi_sense_t;

endpackage : epi_pkg

// ---- rtl/epi_sync.sv ----
// Two-stage synchroniser for a vector of pin levels.
module epi_sync #(
    parameter int WIDTH = 1
)
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end
        else
        begin
            stage1_reg <= async_i;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_o = stage2_reg;

endmodule : epi_sync

// ---- rtl/epi_ext_irq.sv ----
// Dedicated pin and pin-change interrupt unit with a Wishbone register port.
`include "epi_map.svh"
module epi_ext_irq
    import epi_pkg::*;
#(
    parameter int NUM_DED = 3,
    parameter int NUM_GROUPS = 4,
    parameter int GROUP_WIDTH = 8
)
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`EPI_ADR_MSB:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_DED-1:0] dedicated_irq_pins_i,
    input wire logic [NUM_GROUPS*GROUP_WIDTH-1:0] change_detect_inputs_i,
    input wire logic global_irq_enable_i,
    input wire logic sleep_i,
    input wire logic [NUM_DED-1:0] dedicated_served_i,
    input wire logic [NUM_GROUPS-1:0] group_served_i,
    output logic [NUM_DED-1:0] dedicated_request_o,
    output logic [NUM_GROUPS-1:0] change_group_request_o,
    output logic wake_o
);

    localparam int NPC = NUM_GROUPS * GROUP_WIDTH;

    // Field widths are bound by the eight-bit registers and four mask slots.
    generate
        if (NUM_DED < 1 || NUM_DED > 3 || NUM_GROUPS < 1 ||
            NUM_GROUPS > 4 || GROUP_WIDTH != `EPI_BYTE_W)
        begin : g_bad_param
            $error("epi_ext_irq: unsupported parameter values");
        end
    endgenerate

    function automatic logic [NUM_GROUPS-1:0] epi_mask_slot(
        input logic [`EPI_IDX_W-1:0] idx
    );
        logic [3:0] hit4;
        hit4 = {idx == `EPI_IDX_MASK3, idx == `EPI_IDX_MASK2,
                idx == `EPI_IDX_MASK1, idx == `EPI_IDX_MASK0};
        epi_mask_slot = hit4[NUM_GROUPS-1:0];
    endfunction : epi_mask_slot

    logic ack_reg;
    logic [31:0] dat_reg;
    logic [NUM_DED-1:0] ded_en_reg;
    logic [NUM_GROUPS-1:0] grp_en_reg;
    logic [`EPI_SENSE_W*NUM_DED-1:0] sense_reg;
    logic [GROUP_WIDTH-1:0] mask_reg [NUM_GROUPS];
    logic [NUM_DED-1:0] ded_flag_reg;
    logic [NUM_GROUPS-1:0] grp_flag_reg;
    logic [NUM_DED-1:0] ded_prev_reg;
    logic [NPC-1:0] pc_prev_reg;
    logic [`EPI_ARM_W-1:0] arm_reg;
    logic [NUM_DED-1:0] ded_req_reg;
    logic [NUM_GROUPS-1:0] grp_req_reg;
    logic wake_reg;

    logic bus_req;
    logic bus_wr;
    logic ack_next;
    logic [31:0] dat_next;
    logic [`EPI_IDX_W-1:0] reg_idx;
    logic [`EPI_BYTE_W-1:0] wr_byte;
    logic [`EPI_BYTE_W-1:0] rd_byte;
    logic sel_ded_en;
    logic sel_grp_en;
    logic sel_sense;
    logic sel_ded_flag;
    logic sel_grp_flag;
    logic [NUM_GROUPS-1:0] sel_mask;
    logic [GROUP_WIDTH-1:0] mask_rd [NUM_GROUPS+1];
    logic [NUM_DED-1:0] ded_en_next;
    logic [NUM_GROUPS-1:0] grp_en_next;
    logic [`EPI_SENSE_W*NUM_DED-1:0] sense_next;

    logic armed;
    logic [NUM_DED-1:0] ded_pin_eff;
    logic [NUM_DED-1:0] ded_s;
    logic [NPC-1:0] pc_s;
    logic [NPC-1:0] pc_diff;
    logic [NUM_DED-1:0] ded_rise;
    logic [NUM_DED-1:0] ded_fall;
    logic [NUM_DED-1:0] ded_lvl;
    logic [NUM_DED-1:0] ded_hit;
    logic [NUM_DED-1:0] ded_clr;
    logic [NUM_DED-1:0] ded_flag_next;
    logic [NUM_DED-1:0] ded_req_next;
    logic [NUM_GROUPS-1:0] pc_hit;
    logic [NUM_GROUPS-1:0] grp_clr;
    logic [NUM_GROUPS-1:0] grp_flag_next;
    logic [NUM_GROUPS-1:0] grp_req_next;
    logic wake_next;

    // Bus decode. Writes land on the edge at which the master sees ack.
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign bus_wr = bus_req & wb_we_i & wb_sel_i[0] & ack_reg;
    assign reg_idx = wb_adr_i[`EPI_ADR_MSB:`EPI_ADR_LSB];
    assign wr_byte = wb_dat_i[`EPI_BYTE_W-1:0];
    assign sel_ded_en = (reg_idx == `EPI_IDX_DED_EN);
    assign sel_grp_en = (reg_idx == `EPI_IDX_GRP_EN);
    assign sel_sense = (reg_idx == `EPI_IDX_SENSE);
    assign sel_ded_flag = (reg_idx == `EPI_IDX_DED_FLAG);
    assign sel_grp_flag = (reg_idx == `EPI_IDX_GRP_FLAG);
    assign sel_mask = epi_mask_slot(reg_idx);

    assign ded_en_next = (bus_wr & sel_ded_en) ?
        wr_byte[NUM_DED-1:0] : ded_en_reg;
    assign grp_en_next = (bus_wr & sel_grp_en) ?
        wr_byte[NUM_GROUPS-1:0] : grp_en_reg;
    assign sense_next = (bus_wr & sel_sense) ?
        wr_byte[`EPI_SENSE_W*NUM_DED-1:0] : sense_reg;

    assign mask_rd[0] = `EPI_RESET_BYTE;

    // Read mux; unmapped indices answer with zero.
    // Reserved bits zero
    assign rd_byte =
        sel_ded_en ? {{(`EPI_BYTE_W-NUM_DED){1'b0}}, ded_en_reg} :
        sel_grp_en ? {{(`EPI_BYTE_W-NUM_GROUPS){1'b0}}, grp_en_reg} :
        sel_sense ? {{(`EPI_BYTE_W-`EPI_SENSE_W*NUM_DED){1'b0}},
                     sense_reg} :
        sel_ded_flag ? {{(`EPI_BYTE_W-NUM_DED){1'b0}}, ded_flag_reg} :
        sel_grp_flag ? {{(`EPI_BYTE_W-NUM_GROUPS){1'b0}}, grp_flag_reg} :
        mask_rd[NUM_GROUPS];

    assign ack_next = bus_req & ~ack_reg;
    assign dat_next = ack_next ? {`EPI_PAD_ZERO, rd_byte} : '0;

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end
        else
        begin
            ack_reg <= ack_next;
            dat_reg <= dat_next;
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ded_en_reg <= '0;
            grp_en_reg <= '0;
            sense_reg <= '0;
        end
        else
        begin
            ded_en_reg <= ded_en_next;
            grp_en_reg <= grp_en_next;
            sense_reg <= sense_next;
        end
    end

    // Input buffer off
    // A disabled pin reads low in sleep, so a high pin can raise a flag.
    assign ded_pin_eff = dedicated_irq_pins_i &
        ~({NUM_DED{sleep_i}} & ~ded_en_reg);

    // Pad levels sampled
    // Pads are sampled whatever their drive direction, so software can
    // raise an interrupt by driving the pin itself.
    epi_sync #(
        .WIDTH(NPC + NUM_DED)
    ) u_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .async_i({change_detect_inputs_i, ded_pin_eff}),
        .sync_o({pc_s, ded_s})
    );

    // Edges are ignored until the synchroniser has filled after reset.
    assign armed = arm_reg[`EPI_ARM_W-1];

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            arm_reg <= '0;
            ded_prev_reg <= '0;
            pc_prev_reg <= '0;
        end
        else
        begin
            arm_reg <= {arm_reg[`EPI_ARM_W-2:0], 1'b1};
            ded_prev_reg <= ded_s;
            pc_prev_reg <= pc_s;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NUM_DED; i++)
        begin : g_ded
            epi_sense_t mode;
            assign mode = epi_sense_t'(sense_reg[`EPI_SENSE_W*i +:
                                                 `EPI_SENSE_W]);
            assign ded_rise[i] = ded_s[i] & ~ded_prev_reg[i];
            assign ded_fall[i] = ~ded_s[i] & ded_prev_reg[i];
            assign ded_lvl[i] = (mode == EPI_SENSE_LOW);
            assign ded_hit[i] = armed & (
                (mode == EPI_SENSE_ANY) ? (ded_rise[i] | ded_fall[i]) :
                (mode == EPI_SENSE_FALL) ? ded_fall[i] :
                (mode == EPI_SENSE_RISE) & ded_rise[i]);
        end
    endgenerate

    assign ded_clr = ((bus_wr & sel_ded_flag) ?
        wr_byte[NUM_DED-1:0] : '0) | dedicated_served_i;

    // Flag set wins
    // Level mode pins the flag at zero; otherwise a new edge beats a clear.
    assign ded_flag_next = ~ded_lvl &
        ((ded_flag_reg & ~ded_clr) | ded_hit);

    // Level seen live
    // A level that has gone before it is sampled leaves no request behind.
    assign ded_req_next = ded_en_reg & {NUM_DED{global_irq_enable_i}} &
        ((ded_lvl & ~ded_s) | ded_flag_next);

    assign pc_diff = pc_s ^ pc_prev_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_GROUPS; g++)
        begin : g_grp
            always_ff @(posedge mclk_i or negedge reset_n_i)
            begin
                if (!reset_n_i)
                    mask_reg[g] <= `EPI_RESET_BYTE;
                else if (bus_wr & sel_mask[g])
                    mask_reg[g] <= wr_byte;
            end
            assign mask_rd[g+1] = mask_rd[g] |
                (sel_mask[g] ? mask_reg[g] : `EPI_RESET_BYTE);
            // Clocked comparison
            // A toggle that reverts before the clock samples it is not seen.
            assign pc_hit[g] = armed &
                (|(pc_diff[g*GROUP_WIDTH +: GROUP_WIDTH] & mask_reg[g]));
        end
    endgenerate

    assign grp_clr = ((bus_wr & sel_grp_flag) ?
        wr_byte[NUM_GROUPS-1:0] : '0) | group_served_i;
    assign grp_flag_next = (grp_flag_reg & ~grp_clr) | pc_hit;

    assign grp_req_next = grp_en_reg &
        {NUM_GROUPS{global_irq_enable_i}} & grp_flag_next;

    // Wake request
    // Wake-up still relies on this clock; a halted clock needs an outer
    // asynchronous path to the power controller.
    assign wake_next = (|(ded_en_reg & ((ded_lvl & ~ded_s) | ded_hit))) |
        (|(grp_en_reg & pc_hit));

    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ded_flag_reg <= '0;
            grp_flag_reg <= '0;
            ded_req_reg <= '0;
            grp_req_reg <= '0;
            wake_reg <= 1'b0;
        end
        else
        begin
            ded_flag_reg <= ded_flag_next;
            grp_flag_reg <= grp_flag_next;
            ded_req_reg <= ded_req_next;
            grp_req_reg <= grp_req_next;
            wake_reg <= wake_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;
    assign dedicated_request_o = ded_req_reg;
    assign change_group_request_o = grp_req_reg;
    assign wake_o = wake_reg;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_level_flag_zero:
        assert property (ded_lvl[0] |=> !ded_flag_reg[0])
        else $error("level mode flag not held clear");

    a_level_request_low:
        assert property (ded_en_reg[0] && global_irq_enable_i &&
                         ded_lvl[0] && !ded_s[0] |=> dedicated_request_o[0])
        else $error("low level did not raise request");

    a_edge_sets_flag:
        assert property (ded_hit[0] |=> ded_flag_reg[0] ##0
                         (dedicated_request_o[0] == ($past(ded_en_reg[0])
                          && $past(global_irq_enable_i))))
        else $error("edge did not set flag and request");

    a_one_clears_flag:
        assert property (bus_wr && sel_ded_flag && wr_byte[0] &&
                         !ded_hit[0] |=> !ded_flag_reg[0])
        else $error("written one did not clear flag");

    a_zero_keeps_flag:
        assert property (bus_wr && sel_ded_flag && !wr_byte[0] &&
                         ded_flag_reg[0] && !ded_lvl[0] &&
                         !dedicated_served_i[0] |=> ded_flag_reg[0])
        else $error("written zero changed flag");

    a_masked_no_change:
        assert property (!grp_flag_reg[0] && !pc_hit[0] &&
                         !grp_req_reg[0] |=> !grp_req_reg[0] &&
                         !grp_flag_reg[0])
        else $error("group flag rose with no masked change");

    a_group_req_gate:
        assert property (change_group_request_o[0] |->
                         $past(grp_en_reg[0]) &&
                         $past(global_irq_enable_i))
        else $error("group request without enables");

    a_group_change_flag:
        assert property (pc_hit[0] |=> grp_flag_reg[0])
        else $error("masked change did not set group flag");

    a_sense_read_zero:
        assert property (wb_ack_o && $past(sel_sense) |->
                         wb_dat_o[`EPI_BYTE_W-1:`EPI_SENSE_W*NUM_DED] == '0)
        else $error("reserved sense bits read non-zero");

    a_ack_one_cycle:
        assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : epi_ext_irq

// ---- dv/epi_core_model.sv ----
// Behavioural core that vectors to pending pin interrupt requests.
module epi_core_model
(
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic serve_en_i,
    input wire logic [2:0] ded_req_i,
    input wire logic [3:0] grp_req_i,
    output logic [2:0] ded_served_o,
    output logic [3:0] grp_served_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] req_all;
    logic [6:0] served_reg;
    logic [6:0] served_d_reg;
    assign req_all = {grp_req_i, ded_req_i};
    // vector on request.
    // Two quiet cycles after a pulse, so a request still draining is not
    // served twice.
    always_ff @(posedge mclk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            served_reg <= 7'h00;
            served_d_reg <= 7'h00;
        end
        else
        begin
            served_reg <= req_all & ~served_reg & ~served_d_reg
                & {7{serve_en_i}};
            served_d_reg <= served_reg;
        end
    end
    assign ded_served_o = served_reg[2:0];
    assign grp_served_o = served_reg[6:3];
endmodule : epi_core_model

// ---- dv/epi_ext_irq_bench.sv ----
// Self-checking bench for the pin interrupt unit.
`include "epi_map.svh"
module epi_ext_irq_bench import epi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [8:0] adr = 9'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0000_0000;
    logic [31:0] dat_r;
    logic ack;
    logic [2:0] pins = 3'b111;
    logic [31:0] chg = 32'h0000_0000;
    logic gie = 1'b0;
    logic sleep = 1'b0;
    logic serve_en = 1'b0;
    logic [2:0] ded_srv;
    logic [2:0] ded_req;
    logic [3:0] grp_srv;
    logic [3:0] grp_req;
    logic wake;
    int n_errors = 0;
    int checks = 0;

    always #25 mclk_i = ~mclk_i;

    epi_ext_irq u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .dedicated_irq_pins_i(pins), .change_detect_inputs_i(chg),
        .global_irq_enable_i(gie), .sleep_i(sleep),
        .dedicated_served_i(ded_srv), .group_served_i(grp_srv),
        .dedicated_request_o(ded_req), .change_group_request_o(grp_req),
        .wake_o(wake));

    epi_core_model u_core (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
        .serve_en_i(serve_en), .ded_req_i(ded_req), .grp_req_i(grp_req),
        .ded_served_o(ded_srv), .grp_served_o(grp_srv));

    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : wait_n

    // One classic cycle; the request holds until ack is sampled high.
    task automatic wb(input logic w, input logic [6:0] idx,
        input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        dat_w <= {24'h00_0000, d};
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20)
        begin
            n_errors++;
            tally_and_finish();
        end
        @(posedge mclk_i);
    endtask : wb

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, idx, d, q);
    endtask : wr

    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, idx, 8'h00, q);
        chk(q, {24'h00_0000, e});
    endtask : rd_chk

    task automatic t_regs();
        rd_chk(`EPI_IDX_DED_EN, 8'h00);
        rd_chk(`EPI_IDX_SENSE, 8'h00);
        rd_chk(`EPI_IDX_MASK3, 8'h00);
        wr(7'h10, 8'hff);
        rd_chk(7'h10, 8'h00);
        wr(`EPI_IDX_SENSE, 8'hff);
        rd_chk(`EPI_IDX_SENSE, 8'h3f);
        wr(`EPI_IDX_DED_EN, 8'hff);
        rd_chk(`EPI_IDX_DED_EN, 8'h07);
        wr(`EPI_IDX_GRP_EN, 8'hff);
        rd_chk(`EPI_IDX_GRP_EN, 8'h0f);
        wr(`EPI_IDX_DED_EN, 8'h00);
    endtask : t_regs

    task automatic t_edges();
        epi_sense_t m;
        logic [2:0] e;
        gie <= 1'b1;
        for (int i = 1; i < 4; i++)
        begin
            m = epi_sense_t'(i);
            wr(`EPI_IDX_DED_EN, 8'h00);
            wr(`EPI_IDX_SENSE, {2'b00, m, m, m});
            wr(`EPI_IDX_DED_FLAG, 8'h07);
            wr(`EPI_IDX_DED_EN, 8'h07);
            pins <= 3'b000;
            wait_n(4);
            e = (m != EPI_SENSE_RISE) ? 3'b111 : 3'b000;
            chk({29'h0, ded_req}, {29'h0, e});
            rd_chk(`EPI_IDX_DED_FLAG, {5'h00, e});
            wr(`EPI_IDX_DED_FLAG, 8'h07);
            pins <= 3'b111;
            wait_n(4);
            e = (m != EPI_SENSE_FALL) ? 3'b111 : 3'b000;
            chk({29'h0, ded_req}, {29'h0, e});
            wr(`EPI_IDX_DED_FLAG, 8'h00);
            rd_chk(`EPI_IDX_DED_FLAG, {5'h00, e});
            wr(`EPI_IDX_DED_FLAG, 8'h07);
            rd_chk(`EPI_IDX_DED_FLAG, 8'h00);
        end
    endtask : t_edges

    task automatic t_level();
        wr(`EPI_IDX_DED_EN, 8'h00);
        wr(`EPI_IDX_SENSE, 8'h00);
        wr(`EPI_IDX_DED_FLAG, 8'h07);
        wr(`EPI_IDX_DED_EN, 8'h07);
        pins <= 3'b101;
        wait_n(4);
        chk({29'h0, ded_req}, 32'h0000_0002);
        chk({31'h0, wake}, 32'h0000_0001);
        rd_chk(`EPI_IDX_DED_FLAG, 8'h00);
        gie <= 1'b0;
        wait_n(3);
        chk({29'h0, ded_req}, 32'h0000_0000);
        gie <= 1'b1;
        pins <= 3'b111;
        wait_n(4);
        chk({29'h0, ded_req}, 32'h0000_0000);
        chk({31'h0, wake}, 32'h0000_0000);
    endtask : t_level

    task automatic t_sleep();
        wr(`EPI_IDX_DED_EN, 8'h00);
        wr(`EPI_IDX_SENSE, 8'h20);
        sleep <= 1'b1;
        wait_n(4);
        rd_chk(`EPI_IDX_DED_FLAG, 8'h04);
        sleep <= 1'b0;
        wr(`EPI_IDX_DED_FLAG, 8'h07);
    endtask : t_sleep

    task automatic t_serve();
        int n;
        wr(`EPI_IDX_SENSE, 8'h30);
        wr(`EPI_IDX_DED_FLAG, 8'h07);
        wr(`EPI_IDX_DED_EN, 8'h04);
        serve_en <= 1'b1;
        pins <= 3'b011;
        wait_n(3);
        pins <= 3'b111;
        n = 0;
        while (ded_srv[2] !== 1'b1 && n < 12)
        begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 12)
        begin
            n_errors++;
            tally_and_finish();
        end
        chk({31'h0, ded_srv[2]}, 32'h0000_0001);
        wait_n(4);
        rd_chk(`EPI_IDX_DED_FLAG, 8'h00);
        chk({29'h0, ded_req}, 32'h0000_0000);
        serve_en <= 1'b0;
    endtask : t_serve

    task automatic t_groups();
        logic [6:0] mi [4];
        mi = '{`EPI_IDX_MASK0, `EPI_IDX_MASK1, `EPI_IDX_MASK2, `EPI_IDX_MASK3};
        wr(`EPI_IDX_GRP_EN, 8'h0f);
        for (int g = 0; g < 4; g++)
        begin
            wr(mi[g], 8'h01 << g);
            chg <= chg ^ (32'h0000_0010 << (9 * g));
            wait_n(4);
            rd_chk(`EPI_IDX_GRP_FLAG, 8'h00);
            chg <= chg ^ (32'h0000_0001 << (9 * g));
            wait_n(4);
            chk({28'h0, grp_req}, 32'h0000_0001 << g);
            rd_chk(`EPI_IDX_GRP_FLAG, 8'h01 << g);
            wr(`EPI_IDX_GRP_FLAG, 8'h01 << g);
            rd_chk(`EPI_IDX_GRP_FLAG, 8'h00);
            wr(mi[g], 8'h00);
            chg <= chg ^ (32'h0000_0001 << (9 * g));
            wait_n(4);
            rd_chk(`EPI_IDX_GRP_FLAG, 8'h00);
        end
    endtask : t_groups

    initial
    begin
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        wait_n(4);
        t_regs();
        t_edges();
        t_level();
        t_sleep();
        t_serve();
        t_groups();
        tally_and_finish();
    end
endmodule : epi_ext_irq_bench
